/* core/smbc_pkg.sv */
// Shared constants and carrier types for the SPI motor bridge control block
package smbc_pkg;

   // ***********************************
   // Frame geometry
   // ***********************************
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned CNT_W        = 5;
   localparam logic [4:0]  LEN_MIN      = 5'h0F;
   localparam logic [4:0]  LEN_MAX      = 5'h11;
   localparam logic [4:0]  CNT_SAT      = 5'h1F;
   localparam logic [4:0]  CNT_RST      = 5'h00;

   // ***********************************
   // Status word layout and reset values
   // ***********************************
   localparam int unsigned BRIDGE_LSB   = 1;
   localparam int unsigned BRIDGE_MSB   = 12;
   localparam int unsigned BRIDGE_W     = 12;
   localparam logic [15:0] STATUS_RST   = 16'h0000;
   localparam logic [15:0] RX_RST       = 16'h0000;
   localparam logic [2:0]  SYNC_RST     = 3'h0;
   localparam logic [2:0]  CSN_SYNC_RST = 3'h7;

   // ***********************************
   // Carriers
   // ***********************************
   typedef struct packed {
      logic sclk;
      logic sdi;
      logic chip_select_n;
   } smbc_pins_t;

   typedef struct packed {
      logic so;
      logic so_oe_n;
   } smbc_so_t;

   typedef enum logic [1:0] {
      SMBC_IDLE = 2'b01,
      SMBC_XFER = 2'b10
   } smbc_state_t;

endpackage : smbc_pkg

/* core/smbc_top.sv */
// SPI slave that loads bridge switch commands and returns the status word
`timescale 1ns/10ps
// What this block does
// - Falling sclk shifts sdi into 16-bit receiver
// - Rising sclk after the first falling edge advances serial output bit
// - Sclk and sdi accepted only while selected
// - Selection presents status bit 15 first
// - Deselect copies received word into status
// - Status bits 1 to 12 drive switches
// - Serial output released while deselected
// - Frames outside 15 to 17 bits discarded
module smbc_top
   import smbc_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // SPI pins from the master
   input  wire smbc_pkg::smbc_pins_t   pins,
   // Serial output pin
   output smbc_pkg::smbc_so_t          so_pin,
   // Bridge switch commands and status word
   output logic [smbc_pkg::BRIDGE_W-1:0] bridge_cmd,
   output logic [smbc_pkg::FRAME_BITS-1:0] status_word
);
   import smbc_pkg::*;

   // ***********************************
   // Pin synchronisers
   // ***********************************
   // Stage 0 feeds stage 1 only; stage 2 gives the previous value for edges
   logic [2:0]            sclk_sync_reg;
   logic [2:0]            sdi_sync_reg;
   logic [2:0]            csn_sync_reg;
   logic                  sclk_rise;
   logic                  sclk_fall;
   logic                  csn_fall;
   logic                  csn_rise;
   logic                  sdi_s;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sclk_sync_reg <= SYNC_RST;
         sdi_sync_reg  <= SYNC_RST;
         csn_sync_reg  <= CSN_SYNC_RST;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], pins.sclk};
         sdi_sync_reg  <= {sdi_sync_reg[1:0], pins.sdi};
         csn_sync_reg  <= {csn_sync_reg[1:0], pins.chip_select_n};
      end
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   assign csn_fall  = ~csn_sync_reg[1] & csn_sync_reg[2];
   assign csn_rise  = csn_sync_reg[1] & ~csn_sync_reg[2];
   // Sdi is taken one stage later than sclk, so the sampled bit is the one just before the edge
   assign sdi_s     = sdi_sync_reg[2];

   // ***********************************
   // Transfer state
   // ***********************************
   smbc_state_t           state_reg;
   smbc_state_t           state_next;
   logic                  active;
   logic                  len_ok;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SMBC_IDLE: begin
            if (csn_fall) begin
               state_next = SMBC_XFER;
            end
         end
         SMBC_XFER: begin
            if (csn_rise) begin
               state_next = SMBC_IDLE;
            end
         end
         default: begin
            state_next = SMBC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg <= SMBC_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Edges count only while selected and after the falling select edge
   assign active = (state_reg == SMBC_XFER) && !csn_rise;

   // ***********************************
   // Receive path
   // ***********************************
   logic [FRAME_BITS-1:0] rx_reg;
   logic [CNT_W-1:0]      cnt_reg;

   // Master moves sdi on rising edges, so it is steady at the falling one
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_reg <= RX_RST;
      end else if (active && sclk_fall) begin
         rx_reg <= {rx_reg[FRAME_BITS-2:0], sdi_s};
      end
   end

   // Saturating count keeps very long frames from wrapping into range
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_reg <= CNT_RST;
      end else if (csn_fall) begin
         cnt_reg <= CNT_RST;
      end else if (active && sclk_fall && cnt_reg != CNT_SAT) begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // A 15 or 17 bit frame keeps the last 16 bits seen
   assign len_ok = (cnt_reg >= LEN_MIN) && (cnt_reg <= LEN_MAX);

   // ***********************************
   // Status register and bridge drive
   // ***********************************
   logic [FRAME_BITS-1:0] status_reg;
   logic [BRIDGE_W-1:0]   bridge_reg;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         status_reg <= STATUS_RST;
      end else if (state_reg == SMBC_XFER && csn_rise && len_ok) begin
         status_reg <= rx_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         bridge_reg <= STATUS_RST[BRIDGE_MSB:BRIDGE_LSB];
      end else begin
         bridge_reg <= status_reg[BRIDGE_MSB:BRIDGE_LSB];
      end
   end

   assign bridge_cmd  = bridge_reg;
   assign status_word = status_reg;

   // ***********************************
   // Transmit path
   // ***********************************
   logic [FRAME_BITS-1:0] tx_reg;

   // No shift before the first falling edge, so bit 15 is sampled first
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_reg <= STATUS_RST;
      end else if (csn_fall) begin
         tx_reg <= status_reg;
      end else if (active && sclk_rise && cnt_reg != CNT_RST) begin
         tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
      end
   end

   // One assignment for the whole pin struct keeps a single driver
   assign so_pin = '{so:      tx_reg[FRAME_BITS-1],
                     so_oe_n: (state_reg != SMBC_XFER)};

   // ***********************************
   // Checks
   // ***********************************
   sequence s_good_end;
      state_reg == SMBC_XFER && csn_rise && len_ok;
   endsequence

   sequence s_bad_end;
      state_reg == SMBC_XFER && csn_rise && !len_ok;
   endsequence

   a_rx_shift_in: assert property (@(posedge clk) disable iff (!resetn)
      active && sclk_fall |=> rx_reg == {$past(rx_reg[FRAME_BITS-2:0]), $past(sdi_s)})
      else $error("receive shift wrong");

   a_idle_ignore: assert property (@(posedge clk) disable iff (!resetn)
      state_reg == SMBC_IDLE && !csn_fall |=> $stable(rx_reg) && $stable(tx_reg))
      else $error("shift while deselected");

   a_tx_advance: assert property (@(posedge clk) disable iff (!resetn)
      active && sclk_rise && cnt_reg != CNT_RST |=>
         tx_reg == {$past(tx_reg[FRAME_BITS-2:0]), 1'b0})
      else $error("output did not advance");

   a_first_bit: assert property (@(posedge clk) disable iff (!resetn)
      state_reg == SMBC_IDLE && csn_fall |=>
         so_pin.so == $past(status_reg[FRAME_BITS-1]) && !so_pin.so_oe_n)
      else $error("bit 15 not first");

   a_good_load: assert property (@(posedge clk) disable iff (!resetn)
      s_good_end |=> status_reg == $past(rx_reg))
      else $error("status not loaded");

   a_bad_drop: assert property (@(posedge clk) disable iff (!resetn)
      s_bad_end |=> $stable(status_reg) ##1 $stable(bridge_cmd))
      else $error("bad frame loaded");

   a_bridge_map: assert property (@(posedge clk) disable iff (!resetn)
      s_good_end |=> ##1 bridge_cmd == $past(rx_reg[BRIDGE_MSB:BRIDGE_LSB], 2))
      else $error("bridge not driven");

   a_so_release: assert property (@(posedge clk) disable iff (!resetn)
      state_reg == SMBC_IDLE |-> so_pin.so_oe_n)
      else $error("output driven while idle");

   a_hold_bad: assert property (@(posedge clk) disable iff (!resetn)
      !$past(state_reg == SMBC_XFER && csn_rise) |-> $stable(status_reg))
      else $error("status changed outside load");

endmodule : smbc_top

/* tb/smbc_master.sv */
// SPI master model that drives the bridge control block
`timescale 1ns/10ps
module smbc_master
   import smbc_pkg::*;
(
   // Pins towards the block
   output smbc_pkg::smbc_pins_t pins,
   // Serial output from the block
   input  wire smbc_pkg::smbc_so_t so_pin
);
   logic [17:0] rd_word;

   initial begin
      pins = '{sclk: 1'b0, sdi: 1'b0, chip_select_n: 1'b1};
      rd_word = '0;
   end

   // Sclk idles low; with sel low the clocks run while deselected
   task automatic xfer(input int n, input logic [17:0] d, input logic sel);
      pins.chip_select_n = ~sel;
      rd_word = '0;
      for (int i = n - 1; i >= 0; i--) begin
         #62.5 pins.sclk = 1'b1;
         pins.sdi = d[i];
         #62.5 pins.sclk = 1'b0;
         // Released line reads back inverted, so a missing enable shows up
         rd_word = {rd_word[16:0], so_pin.so ^ so_pin.so_oe_n};
      end
      #62.5 pins.chip_select_n = 1'b1;
      pins.sdi = 1'b0;
   endtask : xfer
endmodule : smbc_master

/* tb/tb_top.sv */
// Self-checking bench for the SPI motor bridge control block
`timescale 1ns/10ps
module tb_top;
   import smbc_pkg::*;
   logic                  clk = 1'b0;
   logic                  resetn = 1'b0;
   smbc_pins_t            pins;
   smbc_so_t              so_pin;
   logic [BRIDGE_W-1:0]   bridge_cmd;
   logic [FRAME_BITS-1:0] status_word;
   logic [17:0]           exp_q[$];
   logic [17:0]           m_e;
   logic [15:0]           rx_m = '0;
   logic [15:0]           st_m = '0;
   int                    lens[7] = '{16, 16, 17, 15, 14, 18, 16};
   int                    err_total = 0;
   int                    total_checks = 0;

   always #5 clk = ~clk;

   smbc_master u_smbc_master (.pins(pins), .so_pin(so_pin));
   smbc_top u_smbc_top (.clk(clk), .resetn(resetn), .pins(pins), .so_pin(so_pin),
      .bridge_cmd(bridge_cmd), .status_word(status_word));

   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // Notes the expected readback and status, then runs the frame
   task automatic frame(input int n, input logic sel);
      logic [17:0] d;
      d = 18'($urandom);
      if (sel) begin
         exp_q.push_back({st_m, 2'h0} >> (18 - n));
         for (int i = n - 1; i >= 0; i--) rx_m = {rx_m[14:0], d[i]};
         if (n >= 15 && n <= 17) st_m = rx_m;
         exp_q.push_back({2'h0, st_m});
      end
      @(posedge clk);
      #1;
      u_smbc_master.xfer(n, d, sel);
      repeat (12) @(posedge clk);
      if (!sel) begin
         chk("desel_status", {2'h0, st_m}, {2'h0, status_word});
         chk("desel_oe_n", 18'h1, {17'h0, so_pin.so_oe_n});
      end
      $display("frame of %0d bits done", n);
   endtask : frame

   // Results are due a fixed settle time after deselect
   always @(posedge pins.chip_select_n) begin
      if (resetn === 1'b1) begin
         repeat (8) @(posedge clk);
         #1;
         chk("readback", exp_q.pop_front(), u_smbc_master.rd_word);
         m_e = exp_q.pop_front();
         chk("status_word", m_e, {2'h0, status_word});
         chk("bridge_cmd", {6'h0, m_e[12:1]}, {6'h0, bridge_cmd});
         chk("so_oe_n", 18'h1, {17'h0, so_pin.so_oe_n});
      end
   end

   initial begin
      void'($urandom(74052));
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clk);
      chk("status_rst", {2'h0, STATUS_RST}, {2'h0, status_word});
      chk("oe_n_rst", 18'h1, {17'h0, so_pin.so_oe_n});
      foreach (lens[i]) frame(lens[i], 1'b1);
      frame(16, 1'b0);
      for (int k = 0; k < 20; k++) frame(14 + $urandom_range(4, 0), 1'b1);
      results();
   end

   // Span well beyond the 28 frames of about 2.2 us each
   initial begin
      #200000;
      err_total++;
      $display("watchdog expired");
      results();
   end
endmodule : tb_top
